// ===== hw/pmmsi_regs.sv
// Power management and message interrupt capability registers behind an APB slave
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Power management capability identifier reads 01h and ignores writes.
// - Power management next pointer is read-only, default 8Ch.
// - Power management revision field reads 011b.
// - Wake clock, B2/B3 and bus power/clock control bits always read zero.
// - Auxiliary current defaults to 111b; device-specific initialization defaults to 0.
// - D1 and D2 support bits default to 1.
// - Wake support field defaults to 11111b.
// - Two-bit writable power state, D0..D3hot as 00b..11b, resets to D0.
// - Writing D0 from D3hot pulses the D3 exit output; hot reset only per skip bit, never the fundamental reset pin.
// - Skip-internal-reset bit defaults to 1; when clear, D3hot to D0 resets internally.
// - Wake requests only while the writable wake enable is set; enable resets to 0.
// - Wake status is write-one-to-clear for functions 0 and 1, reads 0 for 2.
// - Message interrupt capability identifier reads 05h.
// - Message interrupt next pointer is read-only, default E0h.
// - Enable and multiple-message enable writable, reset 0; capable fields read 0.
// - Read-only defaults can be preloaded by management bus or EEPROM loader.
module pmmsi_regs
  import pmmsi_pkg::*;
#(
  parameter int unsigned FUNCTION_INDEX = 0
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        preload_valid_i,
  input  wire logic [7:0]  preload_pm_next_i,
  input  wire logic        preload_dev_init_i,
  input  wire logic [2:0]  preload_aux_current_i,
  input  wire logic        preload_d1_support_i,
  input  wire logic        preload_d2_support_i,
  input  wire logic [4:0]  preload_wake_support_i,
  input  wire logic        preload_skip_reset_i,
  input  wire logic [7:0]  preload_msi_next_i,
  input  wire logic        wake_event_i,
  output logic      [1:0]  power_state_o,
  output logic             wake_request_o,
  output logic             d3_exit_o,
  output logic             hot_reset_o
);

  // Only functions 0 and 1 carry a wake status bit
  localparam logic HAS_WAKE_STS = (FUNCTION_INDEX < 2);

  logic [7:0]       pm_next_q;
  logic             dev_init_q;
  logic [2:0]       aux_current_q;
  logic             d1_support_q;
  logic             d2_support_q;
  logic [4:0]       wake_support_q;
  logic             skip_reset_q;
  logic [7:0]       msi_next_q;

  pmmsi_pstate_type pstate_q;
  logic             wake_en_q;
  logic [3:0]       data_sel_q;
  logic             wake_sts_q;
  logic             msi_en_q;
  logic [2:0]       msi_mme_q;
  logic [29:0]      msi_addr_q;
  logic [15:0]      msi_data_q;

  logic [31:0]      prdata_q;
  logic             err_q;
  logic             d3_exit_q;
  logic             hot_reset_q;

  logic             setup;
  logic             access;
  logic             wr_en;
  logic             rd_hit;
  logic [31:0]      rd_word;
  logic             wr_pm_ctrl;
  logic             wr_msi_ctrl;
  logic             wr_msi_addr;
  logic             wr_msi_data;

  assign setup  = psel_i & ~penable_i;
  assign access = psel_i & penable_i;
  // Zero wait states: every access phase completes at its first edge
  assign pready_o  = access;
  assign pslverr_o = access & err_q;
  assign prdata_o  = prdata_q;
  assign wr_en     = access & pwrite_i & ~err_q;

  assign wr_pm_ctrl  = wr_en & (paddr_i == PMMSI_OFF_PM_CTRL);
  assign wr_msi_ctrl = wr_en & (paddr_i == PMMSI_OFF_MSI_CTRL);
  assign wr_msi_addr = wr_en & (paddr_i == PMMSI_OFF_MSI_ADDR);
  assign wr_msi_data = wr_en & (paddr_i == PMMSI_OFF_MSI_DATA);

  // Read word assembly; unlisted bits stay zero
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    unique case (paddr_i)
      PMMSI_OFF_PM_CAP: begin
        rd_word[7:0]                                = PMMSI_PM_CAP_ID;
        rd_word[PMMSI_POS_NEXT +: 8]                = pm_next_q;
        rd_word[PMMSI_POS_REV +: 3]                 = PMMSI_PM_REVISION;
        rd_word[PMMSI_POS_WAKE_CLK]                 = 1'b0;
        rd_word[PMMSI_POS_DEV_INIT]                 = dev_init_q;
        rd_word[PMMSI_POS_AUX_CUR +: 3]             = aux_current_q;
        rd_word[PMMSI_POS_D1_SUP]                   = d1_support_q;
        rd_word[PMMSI_POS_D2_SUP]                   = d2_support_q;
        rd_word[PMMSI_POS_WAKE_SUP +: 5]            = wake_support_q;
      end
      PMMSI_OFF_PM_CTRL: begin
        rd_word[PMMSI_POS_PSTATE +: 2]              = pstate_q;
        rd_word[PMMSI_POS_SKIP_RST]                 = skip_reset_q;
        rd_word[PMMSI_POS_WAKE_EN]                  = wake_en_q;
        rd_word[PMMSI_POS_DATA_SEL +: 4]            = data_sel_q;
        rd_word[PMMSI_POS_WAKE_STS]                 = wake_sts_q;
        rd_word[PMMSI_POS_B2B3]                     = 1'b0;
        rd_word[PMMSI_POS_BPCC]                     = 1'b0;
        rd_word[PMMSI_POS_PM_DATA +: 8]             = PMMSI_PM_DATA_VALUE;
      end
      PMMSI_OFF_MSI_CTRL: begin
        rd_word[7:0]                                = PMMSI_MSI_CAP_ID;
        rd_word[PMMSI_POS_NEXT +: 8]                = msi_next_q;
        rd_word[PMMSI_POS_MSI_EN]                   = msi_en_q;
        rd_word[PMMSI_POS_MSI_MMC +: 3]             = PMMSI_MSI_MMC;
        rd_word[PMMSI_POS_MSI_MME +: 3]             = msi_mme_q;
        rd_word[PMMSI_POS_MSI_64]                   = 1'b0;
      end
      PMMSI_OFF_MSI_ADDR: begin
        rd_word = {msi_addr_q, 2'b00};
      end
      PMMSI_OFF_MSI_DATA: begin
        rd_word[15:0] = msi_data_q;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // Read data and error flag are captured in the setup phase so they come from flops
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      prdata_q <= 32'h0000_0000;
      err_q    <= 1'b0;
    end else if (setup) begin
      prdata_q <= pwrite_i ? 32'h0000_0000 : rd_word;
      err_q    <= ~rd_hit;
    end
  end

  // Preloaded defaults; software writes never reach these
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pm_next_q      <= PMMSI_RST_PM_NEXT;
      dev_init_q     <= PMMSI_RST_DEV_INIT;
      aux_current_q  <= PMMSI_RST_AUX_CUR;
      d1_support_q   <= PMMSI_RST_D1_SUP;
      d2_support_q   <= PMMSI_RST_D2_SUP;
      wake_support_q <= PMMSI_RST_WAKE_SUP;
      skip_reset_q   <= PMMSI_RST_SKIP_RST;
      msi_next_q     <= PMMSI_RST_MSI_NEXT;
    end else if (preload_valid_i) begin
      pm_next_q      <= preload_pm_next_i;
      dev_init_q     <= preload_dev_init_i;
      aux_current_q  <= preload_aux_current_i;
      d1_support_q   <= preload_d1_support_i;
      d2_support_q   <= preload_d2_support_i;
      wake_support_q <= preload_wake_support_i;
      skip_reset_q   <= preload_skip_reset_i;
      msi_next_q     <= preload_msi_next_i;
    end
  end

  // Power state and the D3 exit detection
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pstate_q    <= PMMSI_D0;
      d3_exit_q   <= 1'b0;
      hot_reset_q <= 1'b0;
    end else begin
      d3_exit_q   <= 1'b0;
      hot_reset_q <= 1'b0;
      if (wr_pm_ctrl && pstrb_i[0]) begin
        pstate_q <= pmmsi_pstate_type'(pwdata_i[PMMSI_POS_PSTATE +: 2]);
        if ((pstate_q == PMMSI_D3_HOT) && (pwdata_i[PMMSI_POS_PSTATE +: 2] == PMMSI_D0)) begin
          d3_exit_q   <= 1'b1;
          // The fundamental reset pin is not driven from here at all
          hot_reset_q <= ~skip_reset_q;
        end
      end
    end
  end

  // Wake enable and data select
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wake_en_q  <= 1'b0;
      data_sel_q <= PMMSI_RST_DATA_SEL;
    end else if (wr_pm_ctrl && pstrb_i[1]) begin
      wake_en_q  <= pwdata_i[PMMSI_POS_WAKE_EN];
      data_sel_q <= pwdata_i[PMMSI_POS_DATA_SEL +: 4];
    end
  end

  // Wake status: a new event in the clearing cycle keeps the bit set
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wake_sts_q <= 1'b0;
    end else if (!HAS_WAKE_STS) begin
      wake_sts_q <= 1'b0;
    end else if (wake_event_i) begin
      wake_sts_q <= 1'b1;
    end else if (wr_pm_ctrl && pstrb_i[1] && pwdata_i[PMMSI_POS_WAKE_STS]) begin
      wake_sts_q <= 1'b0;
    end
  end

  // Message control fields have no effect: the message interrupt function is absent
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      msi_en_q  <= 1'b0;
      msi_mme_q <= PMMSI_RST_MSI_MME;
    end else if (wr_msi_ctrl && pstrb_i[2]) begin
      msi_en_q  <= pwdata_i[PMMSI_POS_MSI_EN];
      msi_mme_q <= pwdata_i[PMMSI_POS_MSI_MME +: 3];
    end
  end

  // Message address, byte-lane writes; the two low bits are not stored
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      msi_addr_q[5:0] <= PMMSI_RST_MSI_ADDR[5:0];
    end else if (wr_msi_addr && pstrb_i[0]) begin
      msi_addr_q[5:0] <= pwdata_i[7:2];
    end
  end

  genvar lane;
  generate
    for (lane = 1; lane < 4; lane++) begin : g_addr_lane
      always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
          msi_addr_q[lane*8-2 +: 8] <= PMMSI_RST_MSI_ADDR[lane*8-2 +: 8];
        end else if (wr_msi_addr && pstrb_i[lane]) begin
          msi_addr_q[lane*8-2 +: 8] <= pwdata_i[lane*8 +: 8];
        end
      end
    end
    for (lane = 0; lane < 2; lane++) begin : g_data_lane
      always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
          msi_data_q[lane*8 +: 8] <= PMMSI_RST_MSI_DATA[lane*8 +: 8];
        end else if (wr_msi_data && pstrb_i[lane]) begin
          msi_data_q[lane*8 +: 8] <= pwdata_i[lane*8 +: 8];
        end
      end
    end
  endgenerate

  assign power_state_o  = pstate_q;
  // Wake request needs both a pending event and permission
  assign wake_request_o = wake_en_q & wake_sts_q;
  assign d3_exit_o      = d3_exit_q;
  assign hot_reset_o    = hot_reset_q;

endmodule // pmmsi_regs

`default_nettype wire

// ===== pkg/pmmsi_pkg.sv
// Package with offsets, field positions and reset values of the power management and message interrupt registers
package pmmsi_pkg;

  // Register byte offsets in configuration space
  localparam logic [7:0] PMMSI_OFF_PM_CAP     = 8'h80;
  localparam logic [7:0] PMMSI_OFF_PM_CTRL    = 8'h84;
  localparam logic [7:0] PMMSI_OFF_MSI_CTRL   = 8'h8c;
  localparam logic [7:0] PMMSI_OFF_MSI_ADDR   = 8'h90;
  localparam logic [7:0] PMMSI_OFF_MSI_DATA   = 8'h94;

  // Fixed identifiers and read-only constants
  localparam logic [7:0] PMMSI_PM_CAP_ID      = 8'h01;
  localparam logic [7:0] PMMSI_MSI_CAP_ID     = 8'h05;
  localparam logic [2:0] PMMSI_PM_REVISION    = 3'h3;
  localparam logic [7:0] PMMSI_PM_DATA_VALUE  = 8'h00;
  localparam logic [2:0] PMMSI_MSI_MMC        = 3'h0;

  // Preloadable defaults
  localparam logic [7:0] PMMSI_RST_PM_NEXT    = 8'h8c;
  localparam logic [7:0] PMMSI_RST_MSI_NEXT   = 8'he0;
  localparam logic       PMMSI_RST_DEV_INIT   = 1'b0;
  localparam logic [2:0] PMMSI_RST_AUX_CUR    = 3'h7;
  localparam logic       PMMSI_RST_D1_SUP     = 1'b1;
  localparam logic       PMMSI_RST_D2_SUP     = 1'b1;
  localparam logic [4:0] PMMSI_RST_WAKE_SUP   = 5'h1f;
  localparam logic       PMMSI_RST_SKIP_RST   = 1'b1;

  // Field positions in the power management capability word
  localparam int unsigned PMMSI_POS_NEXT      = 8;
  localparam int unsigned PMMSI_POS_REV       = 16;
  localparam int unsigned PMMSI_POS_WAKE_CLK  = 19;
  localparam int unsigned PMMSI_POS_DEV_INIT  = 21;
  localparam int unsigned PMMSI_POS_AUX_CUR   = 22;
  localparam int unsigned PMMSI_POS_D1_SUP    = 25;
  localparam int unsigned PMMSI_POS_D2_SUP    = 26;
  localparam int unsigned PMMSI_POS_WAKE_SUP  = 27;

  // Field positions in the power management control and status word
  localparam int unsigned PMMSI_POS_PSTATE    = 0;
  localparam int unsigned PMMSI_POS_SKIP_RST  = 3;
  localparam int unsigned PMMSI_POS_WAKE_EN   = 8;
  localparam int unsigned PMMSI_POS_DATA_SEL  = 9;
  localparam int unsigned PMMSI_POS_WAKE_STS  = 15;
  localparam int unsigned PMMSI_POS_B2B3      = 22;
  localparam int unsigned PMMSI_POS_BPCC      = 23;
  localparam int unsigned PMMSI_POS_PM_DATA   = 24;

  // Field positions in the message control word
  localparam int unsigned PMMSI_POS_MSI_EN    = 16;
  localparam int unsigned PMMSI_POS_MSI_MMC   = 17;
  localparam int unsigned PMMSI_POS_MSI_MME   = 20;
  localparam int unsigned PMMSI_POS_MSI_64    = 23;

  // Power states
  typedef enum logic [1:0] {
    PMMSI_D0     = 2'b00,
    PMMSI_D1     = 2'b01,
    PMMSI_D2     = 2'b10,
    PMMSI_D3_HOT = 2'b11
  } pmmsi_pstate_type;

  // Reset values of the writable fields
  localparam logic [3:0]  PMMSI_RST_DATA_SEL  = 4'h0;
  localparam logic [2:0]  PMMSI_RST_MSI_MME   = 3'h0;
  localparam logic [29:0] PMMSI_RST_MSI_ADDR  = 30'h0;
  localparam logic [15:0] PMMSI_RST_MSI_DATA  = 16'h0000;

endpackage

// ===== verif/pmmsi_host.sv
// Configuration access master standing in for the host on the register bus
`timescale 1ns/1ps
`default_nettype none
module pmmsi_host (
  input  wire logic        clk_i,
  input  wire logic        pready_i,
  input  wire logic [31:0] prdata_i,
  input  wire logic        pslverr_i,
  output logic             psel_o,
  output logic             penable_o,
  output logic             pwrite_o,
  output logic      [7:0]  paddr_o,
  output logic      [31:0] pwdata_o,
  output logic      [3:0]  pstrb_o
);
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 8'h00;
    pwdata_o = 32'h0;
    pstrb_o = 4'h0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] rd, output logic err);
    @(posedge clk_i);
    psel_o <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    pstrb_o <= s;
    @(posedge clk_i);
    penable_o <= 1'b1;
    @(posedge clk_i);
    while (pready_i !== 1'b1) @(posedge clk_i);
    rd = prdata_i;
    err = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    // Released lines carry garbage so a slave cannot lean on stale values
    paddr_o <= ~a;
    pwdata_o <= ~d;
  endtask
endmodule // pmmsi_host
`default_nettype wire

// ===== verif/pmmsi_regs_sva.sv
// Checker for the capability register block
`timescale 1ns/1ps
`default_nettype none
module pmmsi_regs_sva (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0]  pstrb_i,
  input wire logic [31:0] prdata_o,
  input wire logic        wake_event_i,
  input wire logic [1:0]  power_state_o,
  input wire logic        wake_request_o,
  input wire logic        d3_exit_o,
  input wire logic        hot_reset_o
);
  logic wr_ctl;
  assign wr_ctl = psel_i && penable_i && pwrite_i && paddr_i == 8'h84;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_rd(logic [7:0] a);
    psel_i && !penable_i && !pwrite_i && paddr_i == a ##1 psel_i && penable_i;
  endsequence
  a_pm_ident: assert property (s_rd(8'h80) |-> prdata_o[7:0] == 8'h01)
    else $error("power management identifier wrong");
  a_pm_rev_fixed: assert property (s_rd(8'h80) |-> prdata_o[19:16] == 4'h3)
    else $error("revision or wake clock bit wrong");
  a_bridge_zero: assert property (s_rd(8'h84) |-> prdata_o[23:22] == 2'b00)
    else $error("bridge extension bits not zero");
  a_msi_fixed: assert property (s_rd(8'h8c) |-> prdata_o[7:0] == 8'h05 && prdata_o[19:17] == 3'h0 && !prdata_o[23])
    else $error("message interrupt fixed fields wrong");
  a_state_reset: assert property ($rose(rst_n_i) |-> power_state_o == 2'b00)
    else $error("power state not D0 after reset");
  a_state_write: assert property (wr_ctl && pstrb_i[0] |=> power_state_o == $past(pwdata_i[1:0]))
    else $error("power state write lost");
  a_d3_exit_pulse: assert property (wr_ctl && pstrb_i[0] && pwdata_i[1:0] == 2'b00 && power_state_o == 2'b11
    |=> d3_exit_o ##1 !d3_exit_o) else $error("missing exit pulse");
  a_exit_cause: assert property (d3_exit_o |-> $past(power_state_o) == 2'b11 && power_state_o == 2'b00)
    else $error("exit pulse without D3 to D0");
  a_hot_with_exit: assert property (hot_reset_o |-> d3_exit_o)
    else $error("internal reset outside exit");
  a_wake_gated: assert property (wr_ctl && pstrb_i[1] && !pwdata_i[8] |=> !wake_request_o)
    else $error("wake request while disabled");
  a_wake_clear: assert property (wr_ctl && pstrb_i[1] && pwdata_i[15] && !wake_event_i |=> !wake_request_o)
    else $error("wake status not cleared");
endmodule // pmmsi_regs_sva
bind pmmsi_regs pmmsi_regs_sva pmmsi_regs_sva_i (.*);
`default_nettype wire

// ===== verif/tb_pm_and_msi_capability_regs.sv
// Self-checking bench for the capability register block
`timescale 1ns/1ps
`default_nettype none
module tb_pm_and_msi_capability_regs;
  import pmmsi_pkg::*;
  logic clk_i = 1'b0, rst_n_i = 1'b0, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, wake_event_i = 1'b0;
  logic [7:0] paddr_i, preload_pm_next_i = 8'h00, preload_msi_next_i = 8'h00;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic [3:0] pstrb_i;
  logic preload_valid_i = 1'b0, preload_dev_init_i = 1'b0, preload_d1_support_i = 1'b0;
  logic preload_d2_support_i = 1'b0, preload_skip_reset_i = 1'b0, err, wake_request_o, f2_wake, d3_exit_o;
  logic hot_reset_o;
  logic [2:0] preload_aux_current_i = 3'h0;
  logic [4:0] preload_wake_support_i = 5'h00;
  logic [1:0] power_state_o;
  int err_total = 0, comparisons = 0, cycles = 0, exit_cnt = 0, hot_cnt = 0;
  pmmsi_regs #(.FUNCTION_INDEX(0)) pmmsi_regs_i (.*);
  pmmsi_regs #(.FUNCTION_INDEX(2)) pmmsi_regs_f2_i (.*, .prdata_o(), .pready_o(), .pslverr_o(),
    .power_state_o(), .wake_request_o(f2_wake), .d3_exit_o(), .hot_reset_o());
  pmmsi_host pmmsi_host_i (.clk_i(clk_i), .pready_i(pready_o), .prdata_i(prdata_o), .pslverr_i(pslverr_o),
    .psel_o(psel_i), .penable_o(penable_i), .pwrite_o(pwrite_i), .paddr_o(paddr_i), .pwdata_o(pwdata_i),
    .pstrb_o(pstrb_i));
  initial forever #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    exit_cnt <= exit_cnt + int'(d3_exit_o === 1'b1);
    hot_cnt <= hot_cnt + int'(hot_reset_o === 1'b1);
    // Run is well under 600 cycles, so this only trips on a hang
    if (cycles == 3000) begin
      err_total++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d, logic [3:0] s);
    pmmsi_host_i.xfer(1'b1, a, d, s, rd, err);
  endtask
  task automatic rdc(logic [7:0] a, logic [31:0] exp);
    pmmsi_host_i.xfer(1'b0, a, 32'h0, 4'h0, rd, err);
    chk($sformatf("read %h", a), rd, exp);
  endtask
  task automatic idle(int n);
    repeat (n) @(posedge clk_i);
  endtask
  initial begin
    idle(6);
    rst_n_i <= 1'b1;
    rdc(PMMSI_OFF_PM_CAP, 32'hffc38c01);
    chk("mapped error", 32'(err), 0);
    rdc(PMMSI_OFF_PM_CTRL, 32'h00000008);
    rdc(PMMSI_OFF_MSI_CTRL, 32'h0000e005);
    rdc(PMMSI_OFF_MSI_ADDR, 32'h0);
    rdc(PMMSI_OFF_MSI_DATA, 32'h0);
    wr(PMMSI_OFF_PM_CAP, 32'hffffffff, 4'hf);
    rdc(PMMSI_OFF_PM_CAP, 32'hffc38c01);
    wr(PMMSI_OFF_MSI_CTRL, 32'hffffffff, 4'hf);
    rdc(PMMSI_OFF_MSI_CTRL, 32'h0071e005);
    wr(PMMSI_OFF_MSI_ADDR, 32'hffffffff, 4'hf);
    rdc(PMMSI_OFF_MSI_ADDR, 32'hfffffffc);
    wr(PMMSI_OFF_MSI_DATA, 32'hffffffff, 4'hf);
    rdc(PMMSI_OFF_MSI_DATA, 32'h0000ffff);
    for (int s = 0; s < 4; s++) begin
      wr(PMMSI_OFF_PM_CTRL, 32'(s), 4'h1);
      rdc(PMMSI_OFF_PM_CTRL, 32'h8 | 32'(s));
      chk("power state", 32'(power_state_o), 32'(s));
    end
    chk("exit pulses before D0", exit_cnt, 0);
    wr(PMMSI_OFF_PM_CTRL, 32'h0, 4'h1);
    idle(3);
    chk("exit pulses", exit_cnt, 1);
    chk("internal resets", hot_cnt, 0);
    {preload_pm_next_i, preload_dev_init_i, preload_aux_current_i} <= {8'h5a, 1'b1, 3'h2};
    {preload_wake_support_i, preload_msi_next_i, preload_valid_i} <= {5'h0a, 8'h3c, 1'b1};
    idle(1);
    preload_valid_i <= 1'b0;
    rdc(PMMSI_OFF_PM_CAP, 32'h50a35a01);
    rdc(PMMSI_OFF_PM_CTRL, 32'h0);
    rdc(PMMSI_OFF_MSI_CTRL, 32'h00713c05);
    wr(PMMSI_OFF_PM_CTRL, 32'h3, 4'h1);
    wr(PMMSI_OFF_PM_CTRL, 32'h0, 4'h1);
    idle(3);
    chk("exit pulses", exit_cnt, 2);
    chk("internal resets", hot_cnt, 1);
    wake_event_i <= 1'b1;
    idle(1);
    wake_event_i <= 1'b0;
    idle(1);
    chk("wake request off", 32'(wake_request_o), 0);
    rdc(PMMSI_OFF_PM_CTRL, 32'h00008000);
    wr(PMMSI_OFF_PM_CTRL, 32'h00000100, 4'h2);
    idle(1);
    chk("wake request on", 32'(wake_request_o), 1);
    chk("function 2 wake", 32'(f2_wake), 0);
    // An event in the clearing cycle must keep the status set
    wake_event_i <= 1'b1;
    wr(PMMSI_OFF_PM_CTRL, 32'h00008100, 4'h2);
    wake_event_i <= 1'b0;
    idle(1);
    chk("wake set wins", 32'(wake_request_o), 1);
    wr(PMMSI_OFF_PM_CTRL, 32'h00008100, 4'h2);
    idle(1);
    chk("wake request cleared", 32'(wake_request_o), 0);
    rdc(PMMSI_OFF_PM_CTRL, 32'h00000100);
    rdc(8'h88, 32'h0);
    chk("unmapped error", 32'(err), 1);
    rst_n_i <= 1'b0;
    idle(2);
    rst_n_i <= 1'b1;
    rdc(PMMSI_OFF_PM_CTRL, 32'h00000008);
    conclude();
  end
endmodule // tb_pm_and_msi_capability_regs
`default_nettype wire
